// [logic/byte_subtractor.sv]
// Eight-bit subtractor with borrow in and full flag generation
`timescale 1ns/1ns
`default_nettype none

module byte_subtractor (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic borrow_in,
  input wire logic prev_zero,
  input wire logic use_chain,
  output logic [7:0] diff,
  output ext_mem_op_pkg::flags_t flags
);
  import ext_mem_op_pkg::*;

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  wire logic [8:0] wide_diff; // Nine-bit result, top bit is borrow out
  wire logic [4:0] low_diff;  // Low nibble result, top bit is nibble borrow
  wire logic sign_a;          // Sign of minuend
  wire logic sign_b;          // Sign of subtrahend
  wire logic ovf;             // Signed overflow

  assign wide_diff = {1'h0, minuend} - {1'h0, subtrahend} - {8'h00, borrow_in};
  assign low_diff = {1'h0, minuend[3:0]} - {1'h0, subtrahend[3:0]} - {4'h0, borrow_in};
  assign diff = wide_diff[7:0];
  assign sign_a = minuend[7];
  assign sign_b = subtrahend[7];
  assign ovf = (sign_a != sign_b) && (wide_diff[7] != sign_a);

  // ==========================================================================
  // Flags
  // ==========================================================================
  assign flags.signed_wrap_flag = ovf;
  assign flags.zero = (wide_diff[7:0] == BYTE_ZERO);
  assign flags.half_carry_flag = ~low_diff[4];
  assign flags.carry = ~wide_diff[8];                 // RULE9
  assign flags.signed_carry_flag = wide_diff[7] ^ ovf;
  // Chained zero is the result zero ANDed with the earlier zero when use_chain is set
  assign flags.combined_zero_flag = use_chain ? (flags.zero & prev_zero) : flags.zero;

endmodule : byte_subtractor

`default_nettype wire

// [logic/ext_mem_op_pkg.sv]
// Package: operation codes, carriers and constants for the extended memory op unit
`default_nettype none
package ext_mem_op_pkg;

  // ==========================================================================
  // Widths and constants
  // ==========================================================================
  localparam int DATA_W = 8;                  // Byte width of operands
  localparam int BIT_SEL_W = 3;               // Width of a bit index
  localparam logic [7:0] BYTE_ONES = 8'hFF;   // Value loaded by whole-byte set
  localparam logic [7:0] BYTE_ZERO = 8'h00;   // Zero byte
  localparam logic [7:0] BYTE_ONE = 8'h01;    // Step for increment and decrement
  localparam logic [1:0] SKIP_CYCLES = 2'h3;  // Cycles taken by a skipping instruction
  localparam logic [7:0] ACC_RESET = 8'h00;   // Working register value after reset
  localparam logic [5:0] FLAGS_RESET = 6'h00; // Status flag value after reset

  // ==========================================================================
  // Operation codes
  // ==========================================================================
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_LEFT_MEM,
    OP_ROTATE_LEFT_TO_ACCUM,
    OP_ROTATE_LEFT_CARRY_MEM,
    OP_ROTATE_LEFT_CARRY_TO_ACCUM,
    OP_ROTATE_RIGHT_MEM,
    OP_ROTATE_RIGHT_TO_ACCUM,
    OP_ROTATE_RIGHT_CARRY_MEM,
    OP_ROTATE_RIGHT_CARRY_TO_ACCUM,
    OP_SUBTRACT_BORROW_TO_ACCUM,
    OP_SUBTRACT_BORROW_TO_MEM,
    OP_SUBTRACT_TO_ACCUM,
    OP_SUBTRACT_TO_MEM,
    OP_DECREMENT_SKIP_ZERO_MEM,
    OP_DECREMENT_SKIP_ZERO_ACCUM,
    OP_INCREMENT_SKIP_ZERO_MEM,
    OP_INCREMENT_SKIP_ZERO_ACCUM,
    OP_SET_ALL,
    OP_SET_BIT,
    OP_SKIP_IF_NONZERO_BIT,
    OP_SKIP_IF_NONZERO,
    OP_SKIP_IF_ZERO,
    OP_NIBBLE_EXCHANGE_MEM,
    OP_NIBBLE_EXCHANGE_TO_ACCUM
  } op_code_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Instruction issued by the sequencer
  typedef struct packed {
    op_code_t op;                  // Operation
    logic [BIT_SEL_W-1:0] bit_sel; // Bit index for bit forms
    logic [DATA_W-1:0] mem_data;   // Byte read from data memory
  } issue_t;

  // Core status flags
  typedef struct packed {
    logic signed_wrap_flag;   // Signed overflow
    logic zero;               // Result zero
    logic half_carry_flag;    // Carry out of low nibble
    logic carry;              // Carry, set when no borrow
    logic signed_carry_flag;  // Sign of true nine-bit result
    logic combined_zero_flag; // Zero over chained subtraction
  } flags_t;

endpackage : ext_mem_op_pkg

`default_nettype wire

// [logic/extended_memory_op_unit.sv]
// Execution datapath for extended-addressing memory operations
`timescale 1ns/1ns
`default_nettype none

// Function
// RULE1: Rotate left memory byte, top to bottom
// RULE2: Rotate right memory byte, bottom to top
// RULE3: Left rotate through carry, nine-bit ring
// RULE4: Right rotate through carry, nine-bit ring
// RULE5: Accumulator rotate forms leave memory intact
// RULE6: Borrow subtract into accumulator, minus inverted carry
// RULE7: Borrow subtract written to memory byte
// RULE8: Plain subtract to accumulator or memory
// RULE9: Carry clear if negative, set otherwise
// RULE10: Subtracts update six status flags
// RULE11: Decrement memory, skip when zero
// RULE12: Accumulator step forms skip on zero
// RULE13: Increment memory, skip when zero
// RULE14: Skip adds dummy cycle, three total
// RULE15: Whole-byte set loads all ones
// RULE16: Bit set forces selected bit only
// RULE17: Bit test skips when bit nonzero
// RULE18: Byte test rewrites, skips when nonzero
// RULE19: Nibble swap, accumulator form spares memory
// RULE20: Zero test rewrites, skips when zero
// RULE21: Dummy cycle changes no architectural state
module extended_memory_op_unit (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic issue_valid,
  input wire ext_mem_op_pkg::issue_t issue,
  output logic busy,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_data,
  output logic [7:0] working_register,
  output ext_mem_op_pkg::flags_t flags,
  output logic skip_next,
  output logic dummy_cycle,
  output logic done
);
  import ext_mem_op_pkg::*;

  // ==========================================================================
  // Sequencing states
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC2,
    ST_DUMMY
  } seq_state_t;

  seq_state_t state_r;       // Current sequence state
  seq_state_t state_nxt;     // Next sequence state

  logic [7:0] acc_r;         // Working register
  logic [7:0] acc_nxt;       // Next working register
  flags_t flags_r;           // Status flags
  flags_t flags_nxt;         // Next status flags
  logic mem_we_r;            // Memory write strobe
  logic mem_we_nxt;          // Next memory write strobe
  logic [7:0] mem_wd_r;      // Memory write data
  logic [7:0] mem_wd_nxt;    // Next memory write data
  logic skip_r;              // Skip request to sequencer
  logic skip_nxt;            // Next skip request
  logic done_r;              // Instruction complete pulse
  logic done_nxt;            // Next complete pulse

  // ==========================================================================
  // Operand decoding
  // ==========================================================================
  wire logic [7:0] m;              // Memory operand
  wire logic c_in;                 // Current carry
  wire logic [7:0] bit_mask;       // One-hot bit select
  wire logic [7:0] rot_l;          // Plain left rotate
  wire logic [7:0] rot_r;          // Plain right rotate
  wire logic [7:0] rot_lc;         // Left rotate through carry
  wire logic [7:0] rot_rc;         // Right rotate through carry
  wire logic [7:0] dec_val;        // Byte minus one
  wire logic [7:0] inc_val;        // Byte plus one
  wire logic [7:0] swap_val;       // Nibble exchanged byte
  wire logic [7:0] sub_diff;       // Subtractor result
  wire flags_t sub_flags;          // Subtractor flags
  wire logic is_borrow_op;         // Borrow subtract selected
  wire logic take;                 // New instruction accepted

  assign m = issue.mem_data;
  assign c_in = flags_r.carry;
  assign bit_mask = BYTE_ONE << issue.bit_sel;
  assign rot_l = {m[6:0], m[7]};             // RULE1
  assign rot_r = {m[0], m[7:1]};             // RULE2
  assign rot_lc = {m[6:0], c_in};            // RULE3
  assign rot_rc = {c_in, m[7:1]};            // RULE4
  assign dec_val = m - BYTE_ONE;             // RULE11
  assign inc_val = m + BYTE_ONE;             // RULE13
  assign swap_val = {m[3:0], m[7:4]};        // RULE19
  assign is_borrow_op = (issue.op == OP_SUBTRACT_BORROW_TO_ACCUM) ||
                        (issue.op == OP_SUBTRACT_BORROW_TO_MEM);
  assign take = issue_valid && (state_r == ST_IDLE);

  // Subtractor, borrow is the inverted carry only for borrow forms
  byte_subtractor u_sub (
    .minuend(acc_r),
    .subtrahend(m),
    .borrow_in(is_borrow_op & ~c_in),        // RULE6
    .prev_zero(flags_r.combined_zero_flag),
    .use_chain(is_borrow_op),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // ==========================================================================
  // Operation execution
  // ==========================================================================
  // Compute every architectural effect of the accepted instruction
  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    mem_we_nxt = 1'h0;
    mem_wd_nxt = mem_wd_r;
    skip_nxt = 1'h0;
    // Only an accepted instruction has any effect
    if (take) begin
      case (issue.op)
        // Memory byte rotates left
        OP_ROTATE_LEFT_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = rot_l;                // RULE1
        end

        // Left rotate into the accumulator
        OP_ROTATE_LEFT_TO_ACCUM: begin
          acc_nxt = rot_l;                   // RULE5
        end

        // Left ring through carry, to memory
        OP_ROTATE_LEFT_CARRY_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = rot_lc;
          flags_nxt.carry = m[7];            // RULE3
        end

        // Left ring through carry, to accumulator
        OP_ROTATE_LEFT_CARRY_TO_ACCUM: begin
          acc_nxt = rot_lc;                  // RULE5
          flags_nxt.carry = m[7];            // RULE3
        end

        // Memory byte rotates right
        OP_ROTATE_RIGHT_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = rot_r;                // RULE2
        end

        // Right rotate into the accumulator
        OP_ROTATE_RIGHT_TO_ACCUM: begin
          acc_nxt = rot_r;                   // RULE5
        end

        // Right ring through carry, to memory
        OP_ROTATE_RIGHT_CARRY_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = rot_rc;
          flags_nxt.carry = m[0];            // RULE4
        end

        // Right ring through carry, to accumulator
        OP_ROTATE_RIGHT_CARRY_TO_ACCUM: begin
          acc_nxt = rot_rc;                  // RULE5
          flags_nxt.carry = m[0];            // RULE4
        end

        // Difference into the accumulator
        OP_SUBTRACT_BORROW_TO_ACCUM, OP_SUBTRACT_TO_ACCUM: begin
          acc_nxt = sub_diff;                // RULE6 RULE8
          flags_nxt = sub_flags;             // RULE10
        end

        // Difference back to memory
        OP_SUBTRACT_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = sub_diff;             // RULE7 RULE8
          flags_nxt = sub_flags;             // RULE10
        end

        // Decrement in memory, skip on zero
        OP_DECREMENT_SKIP_ZERO_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = dec_val;
          skip_nxt = (dec_val == BYTE_ZERO); // RULE11
        end

        // Decrement into accumulator, skip on zero
        OP_DECREMENT_SKIP_ZERO_ACCUM: begin
          acc_nxt = dec_val;
          skip_nxt = (dec_val == BYTE_ZERO); // RULE12
        end

        // Increment in memory, skip on zero
        OP_INCREMENT_SKIP_ZERO_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = inc_val;
          skip_nxt = (inc_val == BYTE_ZERO); // RULE13
        end

        // Increment into accumulator, skip on zero
        OP_INCREMENT_SKIP_ZERO_ACCUM: begin
          acc_nxt = inc_val;
          skip_nxt = (inc_val == BYTE_ZERO); // RULE12
        end

        // Whole byte to ones
        OP_SET_ALL: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = BYTE_ONES;            // RULE15
        end

        // One bit forced high
        OP_SET_BIT: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = m | bit_mask;         // RULE16
        end

        // Bit test, no write
        OP_SKIP_IF_NONZERO_BIT: begin
          skip_nxt = |(m & bit_mask);        // RULE17
        end

        // Rewrite, skip when nonzero
        OP_SKIP_IF_NONZERO: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = m;
          skip_nxt = (m != BYTE_ZERO);       // RULE18
        end

        // Rewrite, skip when zero
        OP_SKIP_IF_ZERO: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = m;
          skip_nxt = (m == BYTE_ZERO);       // RULE20
        end

        // Nibbles exchanged in memory
        OP_NIBBLE_EXCHANGE_MEM: begin
          mem_we_nxt = 1'h1;
          mem_wd_nxt = swap_val;             // RULE19
        end

        // Nibbles exchanged into accumulator
        OP_NIBBLE_EXCHANGE_TO_ACCUM: begin
          acc_nxt = swap_val;                // RULE19
        end

        // No operation
        default: begin
          acc_nxt = acc_r;
        end
      endcase
    end
  end

  // ==========================================================================
  // Cycle sequencing
  // ==========================================================================
  // A skipping instruction runs execute, fetch and one dummy cycle
  always_comb begin
    state_nxt = state_r;
    done_nxt = 1'h0;
    case (state_r)
      // Waiting for an instruction
      ST_IDLE: begin
        if (take && skip_nxt) begin
          state_nxt = ST_EXEC2;              // RULE14
        end else if (take) begin
          done_nxt = 1'h1;
        end
      end
      // Next instruction fetched, still busy
      ST_EXEC2: begin
        state_nxt = ST_DUMMY;                // RULE14
      end
      // Dummy cycle, then release
      ST_DUMMY: begin
        state_nxt = ST_IDLE;
        done_nxt = 1'h1;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  // Architectural state only moves when an instruction is taken
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= ACC_RESET;
      flags_r <= flags_t'(FLAGS_RESET);
    end else begin
      acc_r <= acc_nxt;                      // RULE21
      flags_r <= flags_nxt;                  // RULE21
    end
  end

  // Memory write strobe and data
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_we_r <= 1'h0;
      mem_wd_r <= BYTE_ZERO;
    end else begin
      mem_we_r <= mem_we_nxt;
      mem_wd_r <= mem_wd_nxt;
    end
  end

  // Sequencer handshake
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      skip_r <= 1'h0;
      done_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      skip_r <= take ? skip_nxt : skip_r & (state_r != ST_DUMMY);
      done_r <= done_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign busy = (state_r != ST_IDLE);
  assign mem_wr_en = mem_we_r;
  assign mem_wr_data = mem_wd_r;
  assign working_register = acc_r;
  assign flags = flags_r;
  assign skip_next = skip_r;
  assign dummy_cycle = (state_r == ST_DUMMY); // RULE21
  assign done = done_r;

endmodule : extended_memory_op_unit

`default_nettype wire

// [verif/ext_mem_op_checker_asserts.sv]
// Checker: datapath and skip timing properties of the extended memory op unit
`timescale 1ns/1ns
`default_nettype none

module ext_mem_op_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic issue_valid,
  input wire ext_mem_op_pkg::issue_t issue,
  input wire logic busy,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wr_data,
  input wire logic [7:0] working_register,
  input wire ext_mem_op_pkg::flags_t flags,
  input wire logic skip_next,
  input wire logic dummy_cycle,
  input wire logic done
);
  import ext_mem_op_pkg::*;
  // ======================================
  // Helper samples
  // ======================================
  logic take;          // Instruction accepted this edge
  logic [7:0] m_q;     // Operand seen one edge back
  logic [7:0] acc_q;   // Working register one edge back
  logic c_q;           // Carry one edge back
  logic [2:0] bs_q;    // Bit index one edge back
  assign take = issue_valid && !busy;
  // Sample the operands so results can be tied to their cause
  always_ff @(posedge ref_clk) begin
    m_q <= issue.mem_data;
    acc_q <= working_register;
    c_q <= flags.carry;
    bs_q <= issue.bit_sel;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ======================================
  // Properties
  // ======================================
  rotl_mem_a: assert property (take && issue.op == OP_ROTATE_LEFT_MEM |=> mem_wr_en
    && mem_wr_data == {m_q[6:0], m_q[7]}) else $error("left rotate write wrong");
  rotr_accum_a: assert property (take && issue.op == OP_ROTATE_RIGHT_TO_ACCUM |=> !mem_wr_en
    && working_register == {m_q[0], m_q[7:1]}) else $error("right rotate to accum wrong");
  rlc_ring_a: assert property (take && issue.op == OP_ROTATE_LEFT_CARRY_MEM |=>
    flags.carry == m_q[7] && mem_wr_data == {m_q[6:0], c_q}) else $error("left carry ring wrong");
  rrc_ring_a: assert property (take && issue.op == OP_ROTATE_RIGHT_CARRY_TO_ACCUM |=>
    flags.carry == m_q[0] && working_register == {c_q, m_q[7:1]}) else $error("right ring wrong");
  sub_mem_a: assert property (take && issue.op == OP_SUBTRACT_TO_MEM |=> mem_wr_en
    && mem_wr_data == 8'(acc_q - m_q) && flags.carry == (acc_q >= m_q)) else $error("sub wrong");
  set_bit_a: assert property (take && issue.op == OP_SET_BIT |=>
    mem_wr_data == (m_q | (8'h01 << bs_q))) else $error("bit set wrong");
  zero_test_a: assert property (take && issue.op == OP_SKIP_IF_ZERO |=>
    skip_next == (m_q == 8'h00)) else $error("zero test skip wrong");
  skip_length_a: assert property (take |=> (skip_next |-> busy ##1 (busy && dummy_cycle)
    ##1 (done && !busy && !skip_next))) else $error("skip not three cycles");
  plain_done_a: assert property (take |=> skip_next || done) else $error("no completion");
  dummy_quiet_a: assert property (dummy_cycle |-> !mem_wr_en && $stable(working_register)
    && $stable(flags)) else $error("dummy cycle changed state");
  flags_kept_a: assert property (take && !(issue.op inside {OP_ROTATE_LEFT_CARRY_MEM,
    OP_ROTATE_LEFT_CARRY_TO_ACCUM, OP_ROTATE_RIGHT_CARRY_MEM, OP_ROTATE_RIGHT_CARRY_TO_ACCUM,
    OP_SUBTRACT_BORROW_TO_ACCUM, OP_SUBTRACT_BORROW_TO_MEM, OP_SUBTRACT_TO_ACCUM,
    OP_SUBTRACT_TO_MEM}) |=> $stable(flags)) else $error("flags moved");
endmodule // ext_mem_op_checker

bind extended_memory_op_unit ext_mem_op_checker ext_mem_op_checker_inst (.ref_clk(ref_clk),
  .arst_n(arst_n), .issue_valid(issue_valid), .issue(issue), .busy(busy),
  .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .working_register(working_register),
  .flags(flags), .skip_next(skip_next), .dummy_cycle(dummy_cycle), .done(done));
`default_nettype wire

// [verif/extended_memory_op_unit_tb_top.sv]
// Testbench: operation table, flag cases, refusal while busy and back-to-back issue
`timescale 1ns/1ns
`default_nettype none

module extended_memory_op_unit_tb_top;
  import ext_mem_op_pkg::*;
  // Operand, expected accumulator, {carry, skip}, expected memory afterwards
  typedef struct {
    op_code_t op;
    logic [2:0] bs;
    logic [7:0] m;
    logic [7:0] acc;
    logic [1:0] cs;
    logic [7:0] mem;
  } row_t;
  logic ref_clk, arst_n, issue_valid, load_en;
  logic busy, mem_wr_en, skip_next, dummy_cycle, done;
  op_code_t op_r;
  logic [2:0] bs_r;
  logic [3:0] addr;
  logic [7:0] load_data, rd_data, mem_wr_data, working_register;
  issue_t issue;
  flags_t flags;
  int num_errors = 0;
  int tests_run = 0;
  row_t rows [27] = '{
    '{OP_ROTATE_LEFT_MEM, 3'h0, 8'h81, 8'h00, 2'h0, 8'h03},
    '{OP_ROTATE_RIGHT_MEM, 3'h0, 8'h81, 8'h00, 2'h0, 8'hC0},
    '{OP_ROTATE_LEFT_TO_ACCUM, 3'h0, 8'hA5, 8'h4B, 2'h0, 8'hA5},
    '{OP_ROTATE_RIGHT_TO_ACCUM, 3'h0, 8'hA5, 8'hD2, 2'h0, 8'hA5},
    '{OP_ROTATE_LEFT_CARRY_MEM, 3'h0, 8'h80, 8'hD2, 2'h2, 8'h00},
    '{OP_ROTATE_RIGHT_CARRY_MEM, 3'h0, 8'h01, 8'hD2, 2'h2, 8'h80},
    '{OP_ROTATE_RIGHT_CARRY_TO_ACCUM, 3'h0, 8'h02, 8'h81, 2'h0, 8'h02},
    '{OP_ROTATE_LEFT_CARRY_TO_ACCUM, 3'h0, 8'h80, 8'h00, 2'h2, 8'h80},
    '{OP_ROTATE_LEFT_TO_ACCUM, 3'h0, 8'h28, 8'h50, 2'h2, 8'h28},
    '{OP_SUBTRACT_TO_ACCUM, 3'h0, 8'h10, 8'h40, 2'h2, 8'h10},
    '{OP_SUBTRACT_TO_MEM, 3'h0, 8'h41, 8'h40, 2'h0, 8'hFF},
    '{OP_SUBTRACT_BORROW_TO_ACCUM, 3'h0, 8'h0F, 8'h30, 2'h2, 8'h0F},
    '{OP_SUBTRACT_BORROW_TO_MEM, 3'h0, 8'h30, 8'h30, 2'h2, 8'h00},
    '{OP_DECREMENT_SKIP_ZERO_MEM, 3'h0, 8'h01, 8'h30, 2'h3, 8'h00},
    '{OP_INCREMENT_SKIP_ZERO_MEM, 3'h0, 8'hFF, 8'h30, 2'h3, 8'h00},
    '{OP_INCREMENT_SKIP_ZERO_ACCUM, 3'h0, 8'hFF, 8'h00, 2'h3, 8'hFF},
    '{OP_DECREMENT_SKIP_ZERO_ACCUM, 3'h0, 8'h05, 8'h04, 2'h2, 8'h05},
    '{OP_SET_ALL, 3'h0, 8'h12, 8'h04, 2'h2, 8'hFF},
    '{OP_SET_BIT, 3'h7, 8'h00, 8'h04, 2'h2, 8'h80},
    '{OP_SKIP_IF_NONZERO_BIT, 3'h3, 8'h08, 8'h04, 2'h3, 8'h08},
    '{OP_SKIP_IF_NONZERO_BIT, 3'h3, 8'hF7, 8'h04, 2'h2, 8'hF7},
    '{OP_SKIP_IF_NONZERO, 3'h0, 8'h00, 8'h04, 2'h2, 8'h00},
    '{OP_SKIP_IF_NONZERO, 3'h0, 8'h40, 8'h04, 2'h3, 8'h40},
    '{OP_SKIP_IF_ZERO, 3'h0, 8'h00, 8'h04, 2'h3, 8'h00},
    '{OP_SKIP_IF_ZERO, 3'h0, 8'h01, 8'h04, 2'h2, 8'h01},
    '{OP_NIBBLE_EXCHANGE_MEM, 3'h0, 8'h3C, 8'h04, 2'h2, 8'hC3},
    '{OP_NIBBLE_EXCHANGE_TO_ACCUM, 3'h0, 8'hA7, 8'h7A, 2'h2, 8'hA7}};
  // Subtract chain with full flag results, continuing from the table's last state
  row_t flag_rows [5] = '{
    '{OP_SUBTRACT_TO_ACCUM, 3'h0, 8'h7B, 8'hFF, 2'h0, 8'h7B},
    '{OP_SUBTRACT_BORROW_TO_ACCUM, 3'h0, 8'hFE, 8'h00, 2'h2, 8'hFE},
    '{OP_SUBTRACT_TO_ACCUM, 3'h0, 8'h00, 8'h00, 2'h2, 8'h00},
    '{OP_NIBBLE_EXCHANGE_TO_ACCUM, 3'h0, 8'h08, 8'h80, 2'h2, 8'h08},
    '{OP_SUBTRACT_TO_ACCUM, 3'h0, 8'h01, 8'h7F, 2'h2, 8'h01}};
  logic [5:0] flag_exp [5] = '{6'h02, 6'h1C, 6'h1D, 6'h1D, 6'h26};

  // Operand byte comes straight from the memory model
  assign issue = '{op: op_r, bit_sel: bs_r, mem_data: rd_data};
  extended_memory_op_unit extended_memory_op_unit_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .issue_valid(issue_valid), .issue(issue), .busy(busy), .mem_wr_en(mem_wr_en),
    .mem_wr_data(mem_wr_data), .working_register(working_register), .flags(flags),
    .skip_next(skip_next), .dummy_cycle(dummy_cycle), .done(done));
  mem_sequencer_model mem_sequencer_model_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .addr(addr), .load_en(load_en), .load_data(load_data), .take(issue_valid && !busy),
    .wr_en(mem_wr_en), .wr_data(mem_wr_data), .rd_data(rd_data));

  // ======================================
  // Tasks
  // ======================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [7:0] v);
    @(posedge ref_clk);
    load_en <= 1'h1;
    load_data <= v;
    @(posedge ref_clk);
    load_en <= 1'h0;
  endtask
  // Load operand, issue one instruction, check results, length and memory
  task automatic run_op(input row_t r);
    int n;
    load(r.m);
    issue_valid <= 1'h1;
    op_r <= r.op;
    bs_r <= r.bs;
    @(posedge ref_clk);
    issue_valid <= 1'h0;
    #1;
    check(working_register, r.acc);
    check({7'h0, flags.carry}, {7'h0, r.cs[1]});
    check({7'h0, skip_next}, {7'h0, r.cs[0]});
    n = 1;
    while (done !== 1'h1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(8'(n), r.cs[0] ? 8'h03 : 8'h01);
    @(posedge ref_clk);
    #1;
    check(rd_data, r.mem);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog well beyond the expected run of under two hundred cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
  // ======================================
  // Main sequence
  // ======================================
  initial begin
    arst_n = 1'h0;
    issue_valid = 1'h0;
    op_r = OP_NONE;
    bs_r = 3'h0;
    addr = 4'h5;
    load_en = 1'h0;
    load_data = 8'h00;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'h1;
    #1;
    check(working_register, 8'h00);
    check({2'h0, flags}, 8'h00);
    check({6'h0, busy, done}, 8'h00);
    $display("reset test over");
    for (int i = 0; i < 27; i++) begin
      run_op(rows[i]);
      $display("row %0d over", i);
    end
    for (int i = 0; i < 5; i++) begin
      run_op(flag_rows[i]);
      check({2'h0, flags}, {2'h0, flag_exp[i]});
    end
    $display("flag test over");
    // Skipping op, then a request held during busy must be ignored
    load(8'h01);
    issue_valid <= 1'h1;
    op_r <= OP_DECREMENT_SKIP_ZERO_ACCUM;
    @(posedge ref_clk);
    op_r <= OP_ROTATE_LEFT_TO_ACCUM;
    repeat (2) @(posedge ref_clk);
    issue_valid <= 1'h0;
    #1;
    check(working_register, 8'h00);
    check({7'h0, done}, 8'h01);
    // Two plain ops on consecutive edges
    @(posedge ref_clk);
    issue_valid <= 1'h1;
    @(posedge ref_clk);
    op_r <= OP_NIBBLE_EXCHANGE_TO_ACCUM;
    #1;
    check(working_register, 8'h02);
    @(posedge ref_clk);
    issue_valid <= 1'h0;
    #1;
    check(working_register, 8'h10);
    $display("handshake test over");
    // Reset in mid-instruction
    @(posedge ref_clk);
    issue_valid <= 1'h1;
    op_r <= OP_SKIP_IF_NONZERO;
    @(posedge ref_clk);
    issue_valid <= 1'h0;
    arst_n <= 1'h0;
    #1;
    check(working_register, ACC_RESET);
    check({2'h0, flags}, {2'h0, FLAGS_RESET});
    check({5'h0, busy, skip_next, done}, 8'h00);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'h1;
    run_op(rows[0]);
    $display("reset again test over");
    conclude();
  end
endmodule // extended_memory_op_unit_tb_top
`default_nettype wire

// [verif/mem_sequencer_model.sv]
// Partner: data memory with combinational fetch, as seen from the sequencer side
`timescale 1ns/1ns
`default_nettype none

module mem_sequencer_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic load_en,
  input wire logic [7:0] load_data,
  input wire logic take,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem_r [16]; // Byte store
  logic [3:0] wr_addr_r;  // Address held from the taken instruction
  // Operand fetch is combinational, as the unit expects
  assign rd_data = mem_r[addr];
  // Write-back lands at the address of the instruction that was taken
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_addr_r <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else begin
      if (take) begin
        wr_addr_r <= addr;
      end
      if (wr_en) begin
        mem_r[wr_addr_r] <= wr_data;
      end else if (load_en) begin
        mem_r[addr] <= load_data;
      end
    end
  end
endmodule // mem_sequencer_model
`default_nettype wire
